// ---- common/tcb_defs.vh ----
// Register offsets, field positions, reset values and byte codes of the trace capture buffer.
`ifndef TCB_DEFS_VH
`define TCB_DEFS_VH

// Register byte offsets.
`define TCB_OFF_CTRL      8'h00
`define TCB_OFF_FORMATTER_FLUSH_CONTROL      8'h04
`define TCB_OFF_STATUS    8'h08
`define TCB_OFF_TRIG_CNT  8'h0C
`define TCB_OFF_WR_PTR    8'h10
`define TCB_OFF_RD_PTR    8'h14
`define TCB_OFF_RD_DATA   8'h18
`define TCB_OFF_DEPTH     8'h1C

// Control register fields.
`define TCB_CTRL_CAPT_EN  0

// Formatter and flush control fields.
`define TCB_FORMATTER_FLUSH_CONTROL_FMT_EN   0
`define TCB_FORMATTER_FLUSH_CONTROL_CONT_EN  1
`define TCB_FORMATTER_FLUSH_CONTROL_FLUSH_MAN 4
`define TCB_FORMATTER_FLUSH_CONTROL_STOP_FL  5

// Status fields.
`define TCB_STAT_STOPPED  0
`define TCB_STAT_TRIGGED  1
`define TCB_STAT_FULL     2
`define TCB_STAT_ACQ      3

// Reset values.
`define TCB_RST_FORMATTER_FLUSH_CONTROL      6'h00
`define TCB_RST_TRIG_CNT  32'h00000000

// Stream byte codes.
`define TCB_BYTE_END      8'h01
`define TCB_BYTE_FILL     8'h00
`define TCB_BYTE_TRIG     8'hFF

// Bus answers.
`define TCB_RESP_OKAY     2'h0
`define TCB_RESP_SLVERR   2'h2

`endif

// ---- core/tcb_top.v ----
// Trace capture buffer: ATB sink, byte formatter, circular trace RAM, AXI4-Lite registers.
`timescale 1ns/1ps
`include "tcb_defs.vh"

module tcb_top #(
    parameter ram_addr_width_param = 10
) (
    // Clock and reset.
    input  wire                            core_clk,
    input  wire                            rst_b,
    // AXI4-Lite slave.
    input  wire                            s_axi_awvalid,
    output wire                            s_axi_awready,
    input  wire [7:0]                      s_axi_awaddr,
    input  wire                            s_axi_wvalid,
    output wire                            s_axi_wready,
    input  wire [31:0]                     s_axi_wdata,
    input  wire [3:0]                      s_axi_wstrb,
    output reg                             s_axi_bvalid,
    input  wire                            s_axi_bready,
    output reg  [1:0]                      s_axi_bresp,
    input  wire                            s_axi_arvalid,
    output wire                            s_axi_arready,
    input  wire [7:0]                      s_axi_araddr,
    output reg                             s_axi_rvalid,
    input  wire                            s_axi_rready,
    output reg  [31:0]                     s_axi_rdata,
    output reg  [1:0]                      s_axi_rresp,
    // ATB slave.
    input  wire                            atvalid,
    output wire                            atready,
    input  wire [31:0]                     atdata,
    input  wire [1:0]                      atbytes,
    input  wire [6:0]                      atid,
    output reg                             afvalid,
    input  wire                            afready,
    // Cross trigger unit events and acknowledges.
    input  wire                            trigger_in,
    output wire                            trigger_ack,
    input  wire                            flush_in,
    output wire                            flush_ack,
    output reg                             acq_complete,
    input  wire                            acq_complete_ack,
    output reg                             buffer_full,
    input  wire                            buffer_full_ack,
    // Memory BIST port.
    input  wire                            mem_test_en,
    input  wire [ram_addr_width_param-1:0] bist_addr,
    input  wire                            bist_cs,
    input  wire                            bist_we,
    input  wire [31:0]                     bist_wdata,
    output wire [31:0]                     bist_rdata
);

    localparam AW = ram_addr_width_param;
    localparam DEPTH = 1 << AW;
    localparam [31:0] DEPTH_WORD = DEPTH;
    localparam [AW-1:0] PTR_ONE = 1;
    localparam [AW-1:0] PTR_TOP = {AW{1'b1}};

    // Capture states, one-hot.
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RUN  = 4'h2;
    localparam [3:0] ST_PAD  = 4'h4;
    localparam [3:0] ST_STOP = 4'h8;

    reg  [3:0]    state;
    reg           capture_enable;
    reg  [5:0]    formatter_flush_control;
    reg  [31:0]   trig_cnt;
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [31:0]   beat_data;
    reg  [2:0]    beat_cnt;
    reg           id_pend;
    reg  [7:0]    id_byte;
    reg  [6:0]    last_id;
    reg           trig_pend;
    reg           pad_first;
    reg  [23:0]   word_acc;
    reg  [1:0]    byte_idx;
    reg           triggered;
    reg           wrapped;
    reg           flush_pend;
    reg           ram_we;
    reg  [AW-1:0] ram_wa;
    reg  [31:0]   ram_wd;
    reg  [31:0]   ram_q;
    reg  [31:0]   mem [0:DEPTH-1];

    // Synchronizers: trigger, flush, acq ack, full ack.
    reg  [3:0]    sync_a;
    reg  [3:0]    sync_b;
    reg  [1:0]    sync_d;

    // Bus state.
    reg           aw_held;
    reg           w_held;
    reg  [7:0]    aw_addr;
    reg  [31:0]   w_data;
    reg  [3:0]    w_strb;
    reg           ar_wait;
    reg  [7:0]    ar_addr;

    wire formatting_enable        = formatter_flush_control[`TCB_FORMATTER_FLUSH_CONTROL_FMT_EN];
    wire continuous_format_enable = formatter_flush_control[`TCB_FORMATTER_FLUSH_CONTROL_CONT_EN];
    wire stop_on_flush            = formatter_flush_control[`TCB_FORMATTER_FLUSH_CONTROL_STOP_FL];
    // Mode 10 has no formatting, so it stores like bypass.
    wire fmt_on                   = formatting_enable;
    wire cont_on                  = formatting_enable & continuous_format_enable;
    wire formatter_stopped        = state[0] | state[3];

    wire trig_edge  = sync_b[0] & ~sync_d[0];
    wire flush_edge = sync_b[1] & ~sync_d[1];

    // Write strobes merge byte by byte into the control, formatter and trigger count words; pointer writes ignore them.
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire        wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire        wr_ctrl = wr_fire & (aw_addr == `TCB_OFF_CTRL);
    wire        wr_formatter_flush_control = wr_fire & (aw_addr == `TCB_OFF_FORMATTER_FLUSH_CONTROL);
    wire        wr_tcnt = wr_fire & (aw_addr == `TCB_OFF_TRIG_CNT);
    wire        wr_wptr = wr_fire & (aw_addr == `TCB_OFF_WR_PTR);
    wire        wr_rptr = wr_fire & (aw_addr == `TCB_OFF_RD_PTR);
    wire        wr_ok   = wr_ctrl | wr_formatter_flush_control | wr_tcnt | wr_wptr | wr_rptr;
    wire [31:0] ctrl_nv = ({31'h0, capture_enable} & ~wmask) | (w_data & wmask);
    wire [31:0] formatter_flush_control_nv = ({26'h0, formatter_flush_control} & ~wmask) | (w_data & wmask);
    wire [31:0] tcnt_nv = (trig_cnt & ~wmask) | (w_data & wmask);
    wire        rd_adv  = ar_wait & (ar_addr == `TCB_OFF_RD_DATA);

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~ar_wait & ~s_axi_rvalid;

    // Stopped or idle capture still takes every beat and drops it.
    assign atready = (state[1] & (beat_cnt == 3'h0) & ~id_pend) | state[0] | state[3];
    wire at_take = atvalid & atready & state[1];

    // Byte picker: identifier mark, beat bytes, trigger mark, then stop padding.
    reg        emit;
    reg  [7:0] ebyte;
    reg        pad_done;
    always @* begin
        emit     = 1'b0;
        ebyte    = `TCB_BYTE_FILL;
        pad_done = 1'b0;
        if (state[1] | state[2]) begin
            if (id_pend) begin
                emit  = 1'b1;
                ebyte = id_byte;
            end else if (beat_cnt != 3'h0) begin
                emit  = 1'b1;
                ebyte = beat_data[7:0];
            end else if (trig_pend) begin
                emit  = 1'b1;
                ebyte = `TCB_BYTE_TRIG;
            end else if (state[2]) begin
                if (pad_first & (~fmt_on | (byte_idx != 2'h0))) begin
                    emit  = 1'b1;
                    ebyte = `TCB_BYTE_END;
                end else if (byte_idx != 2'h0) begin
                    emit  = 1'b1;
                    ebyte = `TCB_BYTE_FILL;
                end else begin
                    pad_done = 1'b1;
                end
            end
        end
    end

    wire word_done = emit & (byte_idx == 2'h3);
    wire stop_cond = (~capture_enable) | (triggered & (trig_cnt == 32'h0)) |
                     (afvalid & afready & stop_on_flush);

    // Bus write channel: address and data are held in either order, then answered together.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TCB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `TCB_RESP_OKAY : `TCB_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Bus read channel: one wait cycle lets the RAM port settle on a fresh read pointer.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ar_wait      <= 1'b0;
            ar_addr      <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `TCB_RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                ar_wait <= 1'b1;
                ar_addr <= {s_axi_araddr[7:2], 2'b00};
            end
            if (ar_wait) begin
                ar_wait      <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TCB_RESP_OKAY;
                case (ar_addr)
                    `TCB_OFF_CTRL:     s_axi_rdata <= {31'h0, capture_enable};
                    `TCB_OFF_FORMATTER_FLUSH_CONTROL:     s_axi_rdata <= {26'h0, formatter_flush_control};
                    `TCB_OFF_STATUS:   s_axi_rdata <= {28'h0, acq_complete, wrapped, triggered,
                                                       formatter_stopped};
                    `TCB_OFF_TRIG_CNT: s_axi_rdata <= trig_cnt;
                    `TCB_OFF_WR_PTR:   s_axi_rdata <= {{(32-AW){1'b0}}, wr_ptr};
                    `TCB_OFF_RD_PTR:   s_axi_rdata <= {{(32-AW){1'b0}}, rd_ptr};
                    `TCB_OFF_RD_DATA:  s_axi_rdata <= mem_test_en ? 32'h00000000 : ram_q;
                    `TCB_OFF_DEPTH:    s_axi_rdata <= DEPTH_WORD;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `TCB_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Cross trigger lines come from another domain: two flops, then edge detect on the second for trigger and flush only.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_d <= 2'h0;
        end else begin
            sync_a <= {buffer_full_ack, acq_complete_ack, flush_in, trigger_in};
            sync_b <= sync_a;
            sync_d <= sync_b[1:0];
        end
    end

    // Acknowledges return the synchronized level, closing each event handshake.
    assign trigger_ack = sync_b[0];
    assign flush_ack   = sync_b[1];

    // Capture engine, registers and stream formatter.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state                   <= ST_IDLE;
            capture_enable          <= 1'b0;
            formatter_flush_control <= `TCB_RST_FORMATTER_FLUSH_CONTROL;
            trig_cnt                <= `TCB_RST_TRIG_CNT;
            wr_ptr                  <= {AW{1'b0}};
            rd_ptr                  <= {AW{1'b0}};
            beat_data               <= 32'h00000000;
            beat_cnt                <= 3'h0;
            id_pend                 <= 1'b0;
            id_byte                 <= 8'h00;
            last_id                 <= 7'h00;
            trig_pend               <= 1'b0;
            pad_first               <= 1'b0;
            word_acc                <= 24'h000000;
            byte_idx                <= 2'h0;
            triggered               <= 1'b0;
            wrapped                 <= 1'b0;
            flush_pend              <= 1'b0;
            afvalid                 <= 1'b0;
            ram_we                  <= 1'b0;
            ram_wa                  <= {AW{1'b0}};
            ram_wd                  <= 32'h00000000;
            acq_complete            <= 1'b0;
            buffer_full             <= 1'b0;
        end else begin
            ram_we <= 1'b0;
            // Register writes from software.
            if (wr_formatter_flush_control)
                formatter_flush_control <= {formatter_flush_control_nv[5], 1'b0, formatter_flush_control_nv[3:0]};
            if (wr_tcnt)
                trig_cnt <= tcnt_nv;
            if (wr_rptr)
                rd_ptr <= w_data[AW-1:0];
            else if (rd_adv)
                rd_ptr <= rd_ptr + PTR_ONE;
            if (wr_wptr)
                wr_ptr <= w_data[AW-1:0];
            if (wr_ctrl) begin
                capture_enable <= ctrl_nv[`TCB_CTRL_CAPT_EN];
                if (ctrl_nv[`TCB_CTRL_CAPT_EN] & formatter_stopped) begin
                    state     <= ST_RUN;
                    triggered <= 1'b0;
                    wrapped   <= 1'b0;
                    last_id   <= 7'h00;
                    byte_idx  <= 2'h0;
                end
            end
            // Flush requests: one held at a time, served one after another.
            if (afvalid & afready)
                afvalid <= 1'b0;
            else if (~afvalid & flush_pend) begin
                afvalid    <= 1'b1;
                flush_pend <= 1'b0;
            end
            // A new request in the cycle that a pending one is served stays pending.
            if (flush_edge | (wr_formatter_flush_control & formatter_flush_control_nv[`TCB_FORMATTER_FLUSH_CONTROL_FLUSH_MAN]))
                flush_pend <= 1'b1;
            // Beat intake and identifier change marks.
            if (at_take) begin
                beat_data <= atdata;
                beat_cnt  <= {1'b0, atbytes} + 3'h1;
                last_id   <= atid;
                if (fmt_on & (atid != last_id)) begin
                    id_pend <= 1'b1;
                    id_byte <= {atid, 1'b1};
                end
            end
            // Byte consumption.
            if (emit) begin
                if (id_pend)
                    id_pend <= 1'b0;
                else if (beat_cnt != 3'h0) begin
                    beat_data <= {8'h00, beat_data[31:8]};
                    beat_cnt  <= beat_cnt - 3'h1;
                end else if (trig_pend)
                    trig_pend <= 1'b0;
                else
                    pad_first <= 1'b0;
                byte_idx <= byte_idx + 2'h1;
                word_acc <= {ebyte, word_acc[23:8]};
            end
            // Trigger events count only while capturing; set after consumption so a new one is never lost.
            if (trig_edge & state[1]) begin
                triggered <= 1'b1;
                if (cont_on)
                    trig_pend <= 1'b1;
            end
            // Word store into the circular RAM.
            if (word_done & ~mem_test_en) begin
                ram_we <= 1'b1;
                ram_wa <= wr_ptr;
                ram_wd <= {ebyte, word_acc[23:0]};
                wr_ptr <= wr_ptr + PTR_ONE;
                if (wr_ptr == PTR_TOP) begin
                    wrapped     <= 1'b1;
                    buffer_full <= 1'b1;
                end
                if (triggered & (trig_cnt != 32'h0))
                    trig_cnt <= trig_cnt - 32'h1;
            end
            // Stop sequence: drain the current beat, pad to a word, then stop.
            if (state[1] & stop_cond) begin
                state     <= ST_PAD;
                pad_first <= 1'b1;
            end
            if (state[2] & pad_done)
                state <= ST_STOP;
            // Ack clears the event line; a new event in the same cycle wins.
            if (sync_b[2])
                acq_complete <= 1'b0;
            if (state[2] & pad_done & (trig_cnt == 32'h0))
                acq_complete <= 1'b1;
            if (sync_b[3] & ~(word_done & (wr_ptr == PTR_TOP)))
                buffer_full <= 1'b0;
        end
    end

    // Trace RAM on the trace clock; memory test takes both the write and the read port when enabled.
    wire          m_we = mem_test_en ? (bist_cs & bist_we) : ram_we;
    wire [AW-1:0] m_wa = mem_test_en ? bist_addr : ram_wa;
    wire [31:0]   m_wd = mem_test_en ? bist_wdata : ram_wd;
    wire [AW-1:0] m_ra = mem_test_en ? bist_addr : rd_ptr;
    always @(posedge core_clk) begin
        if (m_we)
            mem[m_wa] <= m_wd;
        ram_q <= mem[m_ra];
    end

    assign bist_rdata = ram_q;

endmodule // tcb_top

// ---- test/tcb_monitor.sv ----
// Checker of bus, flush and memory-test timing at the trace capture buffer ports.
`timescale 1ns/1ps
module tcb_monitor #(parameter ram_addr_width_param = 10) (
    // Clock, reset and bus handshakes.
    input wire logic                            core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic                            s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic                            s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]                      s_axi_bresp, s_axi_rresp,
    input wire logic [7:0]                      s_axi_araddr,
    input wire logic [31:0]                     s_axi_rdata, bist_wdata, bist_rdata,
    // Flush handshake and memory test port.
    input wire logic                            afvalid, afready, mem_test_en, bist_cs, bist_we,
    input wire logic [ram_addr_width_param-1:0] bist_addr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Answers stay put until taken, since a master may stall for any time.
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed before it was taken");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before it was taken");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer not two cycles after address");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1F |-> ##2 s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles after address");
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_flush_held: assert property (afvalid && !afready |=> afvalid)
        else $error("flush request dropped before answer");
    // Memory test reads return last written word one cycle later.
    a_bist_readback: assert property (mem_test_en && bist_cs && bist_we ##1 mem_test_en && !bist_we &&
        bist_addr == $past(bist_addr) |=> bist_rdata == $past(bist_wdata, 2)) else $error("memory test readback wrong");
endmodule // tcb_monitor

bind tcb_top tcb_monitor #(.ram_addr_width_param(ram_addr_width_param)) i_tcb_monitor (.core_clk, .rst_b,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rresp, .s_axi_araddr, .s_axi_rdata,
    .bist_wdata, .bist_rdata, .afvalid, .afready, .mem_test_en, .bist_cs, .bist_we, .bist_addr);

// ---- test/tcb_atb_src.sv ----
// Trace source model: offers beats on the trace port and answers flush requests.
`timescale 1ns/1ps
module tcb_atb_src (
    // Clock, reset and trace port.
    input wire logic   core_clk, rst_b, atready, afvalid,
    output logic       atvalid = 1'h0, afready = 1'h0,
    output logic [31:0] atdata = 32'h0,
    output logic [1:0]  atbytes = 2'h0,
    output logic [6:0]  atid = 7'h05
);
    // One beat held until taken; idle data shows the inverse so stale bytes cannot pass for new ones.
    task automatic send(input logic [31:0] d, input logic [1:0] n);
        @(posedge core_clk);
        atvalid <= 1'h1;
        atdata <= d;
        atbytes <= n;
        do @(negedge core_clk); while (!atready);
        @(posedge core_clk);
        atvalid <= 1'h0;
        atdata <= ~d;
    endtask
    // Flush requests are answered one cycle late, so the held request is seen.
    always @(posedge core_clk) afready <= afvalid && !afready;
endmodule // tcb_atb_src

// ---- test/testbench.sv ----
// Self-checking bench of the trace capture buffer: registers, capture, wrap, trigger, flush, memory test.
`timescale 1ns/1ps
`include "tcb_defs.vh"
module testbench;
    localparam int AW = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic core_clk = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, trigger_in = 1'h0, flush_in = 1'h0, acq_complete_ack = 1'h0;
    logic buffer_full_ack = 1'h0, mem_test_en = 1'h0, bist_cs = 1'h0, bist_we = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, bist_wdata = 32'h0;
    logic [AW-1:0] bist_addr = 4'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, atvalid, atready, afvalid, afready;
    wire trigger_ack, flush_ack, acq_complete, buffer_full;
    wire [1:0] s_axi_bresp, s_axi_rresp, atbytes;
    wire [31:0] s_axi_rdata, atdata, bist_rdata;
    wire [6:0] atid;
    int n_errors = 0, tests_run = 0, cyc = 0;
    tcb_top #(.ram_addr_width_param(AW)) i_tcb_top (.core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .atvalid, .atready, .atdata, .atbytes, .atid, .afvalid, .afready, .trigger_in, .trigger_ack,
        .flush_in, .flush_ack, .acq_complete, .acq_complete_ack, .buffer_full, .buffer_full_ack, .mem_test_en,
        .bist_addr, .bist_cs, .bist_we, .bist_wdata, .bist_rdata);
    tcb_atb_src i_tcb_atb_src (.core_clk, .rst_b, .atready, .afvalid, .atvalid, .afready, .atdata, .atbytes, .atid);
    // Clock and a cycle ceiling that cuts a hang short.
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 6000) begin
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        final_report();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks open one edge late so a strobe never changes twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
        do @(negedge core_clk); while (!(s_axi_awready && s_axi_wready));
        @(posedge core_clk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(negedge core_clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
        @(posedge core_clk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
        do @(negedge core_clk); while (!s_axi_arready);
        @(posedge core_clk);
        s_axi_arvalid <= 1'h0;
        do @(negedge core_clk); while (!s_axi_rvalid);
        chk(s_axi_rdata & m, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        @(posedge core_clk);
        s_axi_rready <= 1'h0;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'h1;
        // Reset values, a read-only register and an unmapped place.
        rd(`TCB_OFF_FORMATTER_FLUSH_CONTROL, ALL, 32'h0, `TCB_RESP_OKAY);
        rd(`TCB_OFF_DEPTH, ALL, 32'h10, `TCB_RESP_OKAY);
        rd(8'h20, ALL, 32'h0, `TCB_RESP_SLVERR);
        wr(`TCB_OFF_STATUS, 32'h1, `TCB_RESP_SLVERR);
        $display("registers done");
        // Bypass: sixteen words wrap the ring, a short beat is then closed with the end mark.
        wr(`TCB_OFF_CTRL, 32'h1, `TCB_RESP_OKAY);
        for (int i = 0; i < 16; i++) i_tcb_atb_src.send(32'hA5000000 + i, 2'h3);
        i_tcb_atb_src.send(32'h00006655, 2'h1);
        repeat (8) @(posedge core_clk);
        chk(buffer_full, 1'h1);
        wr(`TCB_OFF_CTRL, 32'h0, `TCB_RESP_OKAY);
        repeat (8) @(posedge core_clk);
        rd(`TCB_OFF_STATUS, 32'h7, 32'h5, `TCB_RESP_OKAY);
        chk(atready, 1'h1);
        rd(`TCB_OFF_WR_PTR, ALL, 32'h1, `TCB_RESP_OKAY);
        wr(`TCB_OFF_RD_PTR, 32'h0, `TCB_RESP_OKAY);
        rd(`TCB_OFF_RD_DATA, ALL, 32'h00016655, `TCB_RESP_OKAY);
        rd(`TCB_OFF_RD_DATA, ALL, 32'hA5000001, `TCB_RESP_OKAY);
        i_tcb_atb_src.send(32'h12345678, 2'h3);
        rd(`TCB_OFF_WR_PTR, ALL, 32'h1, `TCB_RESP_OKAY);
        {acq_complete_ack, buffer_full_ack} <= 2'h3;
        repeat (5) @(posedge core_clk);
        chk(buffer_full, 1'h0);
        {acq_complete_ack, buffer_full_ack} <= 2'h0;
        $display("bypass wrap done");
        // Trigger with one word left to store ends capture and reports completion.
        wr(`TCB_OFF_TRIG_CNT, 32'h1, `TCB_RESP_OKAY);
        wr(`TCB_OFF_CTRL, 32'h1, `TCB_RESP_OKAY);
        trigger_in <= 1'h1;
        i_tcb_atb_src.send(32'h11111111, 2'h3);
        i_tcb_atb_src.send(32'h22222222, 2'h3);
        for (int i = 0; i < 40 && acq_complete !== 1'h1; i++) @(posedge core_clk);
        chk(acq_complete, 1'h1);
        chk(trigger_ack, 1'h1);
        rd(`TCB_OFF_STATUS, 32'h3, 32'h3, `TCB_RESP_OKAY);
        rd(`TCB_OFF_TRIG_CNT, ALL, 32'h0, `TCB_RESP_OKAY);
        trigger_in <= 1'h0;
        $display("trigger done");
        // Flush from the event line, with capture stopping once it is answered.
        wr(`TCB_OFF_FORMATTER_FLUSH_CONTROL, 32'h20, `TCB_RESP_OKAY);
        wr(`TCB_OFF_CTRL, 32'h1, `TCB_RESP_OKAY);
        flush_in <= 1'h1;
        for (int i = 0; i < 20 && afvalid !== 1'h1; i++) @(posedge core_clk);
        chk(afvalid, 1'h1);
        repeat (8) @(posedge core_clk);
        chk(flush_ack, 1'h1);
        rd(`TCB_OFF_STATUS, 32'h1, 32'h1, `TCB_RESP_OKAY);
        flush_in <= 1'h0;
        $display("flush done");
        // Normal mode: an identifier mark opens the stream, the stop pads the open word.
        wr(`TCB_OFF_FORMATTER_FLUSH_CONTROL, 32'h1, `TCB_RESP_OKAY);
        wr(`TCB_OFF_CTRL, 32'h1, `TCB_RESP_OKAY);
        i_tcb_atb_src.send(32'h44332211, 2'h3);
        wr(`TCB_OFF_CTRL, 32'h0, `TCB_RESP_OKAY);
        wr(`TCB_OFF_RD_PTR, 32'h5, `TCB_RESP_OKAY);
        rd(`TCB_OFF_RD_DATA, ALL, 32'h3322110B, `TCB_RESP_OKAY);
        rd(`TCB_OFF_RD_DATA, ALL, 32'h00000144, `TCB_RESP_OKAY);
        $display("normal mode done");
        // Memory test port owns the memory: write a word, read it back.
        {mem_test_en, bist_cs, bist_we, bist_addr, bist_wdata} <= {3'h7, 4'h3, 32'hC0DE0003};
        @(posedge core_clk);
        bist_we <= 1'h0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(bist_rdata, 32'hC0DE0003);
        repeat (2) @(posedge core_clk);
        $display("memory test done");
        final_report();
    end
endmodule // testbench
